// file: rtl/audio_adc_interrupt_unit.sv
`default_nettype none
module audio_adc_interrupt_unit #(
  parameter int PULSE_CYCLES  = irq_unit_pkg::PULSE_CYC,
  parameter int PERIOD_CYCLES = irq_unit_pkg::PERIOD_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  input  wire logic       i_serial_clk_err,
  input  wire logic       i_pll_lock,
  input  wire logic       i_mix_saturate,
  input  wire logic       i_voice_up,
  input  wire logic       i_voice_down,
  output logic      [1:0] o_chan_a_cm_tolerance,
  output logic      [1:0] o_chan_b_cm_tolerance,
  output logic            o_irq_active_low_pin
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]  cfg_r, cfg_nxt;
  logic [7:0]  mask_r, mask_nxt;
  logic [7:0]  flags_r, flags_nxt;
  logic [7:0]  cmtol_r, cmtol_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic [7:0]  events;
  logic [7:0]  visible;
  logic [1:0]  mode;
  logic        flag_pending;
  logic        new_event;

  // ----------------------------------------------------------------
  // event gathering and flag readback view
  // ----------------------------------------------------------------
  // gather sources into flag positions
  always_comb begin
    events = 8'h00;
    events[irq_unit_pkg::POS_SERIAL_CLK_ERR] = i_serial_clk_err;
    events[irq_unit_pkg::POS_PLL_LOCK]       = i_pll_lock;
    events[irq_unit_pkg::POS_MIX_SATURATE]   = i_mix_saturate;
    events[irq_unit_pkg::POS_VOICE_UP]       = i_voice_up;
    events[irq_unit_pkg::POS_VOICE_DOWN]     = i_voice_down;
  end

  // readback view of the flags
  always_comb begin
    if (cfg_r[irq_unit_pkg::POS_FLAG_READBACK_SELECT]) begin
      visible = flags_r & ~mask_r;
    end else begin
      visible = flags_r;
    end
    visible[2:0] = 3'h0;
  end

  // ----------------------------------------------------------------
  // register access decode
  // ----------------------------------------------------------------
  logic        wr_cfg;
  logic        wr_mask;
  logic        wr_cmtol;
  logic        rd_flags;

  // one strobe per register; unmapped writes match none of them
  assign wr_cfg   = i_reg_wr &&
                    (i_reg_addr == irq_unit_pkg::ADDR_INTERRUPT_CONFIG);
  assign wr_mask  = i_reg_wr &&
                    (i_reg_addr == irq_unit_pkg::ADDR_INTERRUPT_MASKS);
  assign wr_cmtol = i_reg_wr &&
                    (i_reg_addr == irq_unit_pkg::ADDR_COMMON_MODE_TOLERANCE);
  assign rd_flags = i_reg_rd &&
                    (i_reg_addr == irq_unit_pkg::ADDR_INTERRUPT_LATCHED_FLAGS);

  // ----------------------------------------------------------------
  // interrupt configuration
  // ----------------------------------------------------------------
  // reserved bits never take a written one
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_cfg) begin
      cfg_nxt = i_reg_wdata & irq_unit_pkg::WMASK_INTERRUPT_CONFIG;
    end
  end

  // config register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg_r <= irq_unit_pkg::RST_INTERRUPT_CONFIG;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt masks
  // ----------------------------------------------------------------
  // stored as written, the low bits included
  always_comb begin
    mask_nxt = mask_r;
    if (wr_mask) begin
      mask_nxt = i_reg_wdata;
    end
  end

  // mask register; every source starts masked
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mask_r <= irq_unit_pkg::RST_INTERRUPT_MASKS;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // common-mode tolerance
  // ----------------------------------------------------------------
  // only the two channel fields are kept
  always_comb begin
    cmtol_nxt = cmtol_r;
    if (wr_cmtol) begin
      cmtol_nxt = i_reg_wdata &
                  irq_unit_pkg::WMASK_COMMON_MODE_TOLERANCE;
    end
  end

  // tolerance register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cmtol_r <= irq_unit_pkg::RST_COMMON_MODE_TOLERANCE;
    end else begin
      cmtol_r <= cmtol_nxt;
    end
  end

  // ----------------------------------------------------------------
  // latched flags
  // ----------------------------------------------------------------
  // a read clears only what it showed; a new event wins over the clear
  always_comb begin
    flags_nxt = flags_r;
    if (rd_flags) begin
      flags_nxt = flags_r & ~visible;
    end
    flags_nxt = (flags_nxt | events) & 8'hF8;
  end

  // latched flag register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      flags_r <= irq_unit_pkg::RST_INTERRUPT_LATCHED_FLAGS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // holds the last read until the next one; unmapped reads give zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        irq_unit_pkg::ADDR_INTERRUPT_CONFIG:        rdata_nxt = cfg_r;
        irq_unit_pkg::ADDR_INTERRUPT_MASKS:         rdata_nxt = mask_r;
        irq_unit_pkg::ADDR_INTERRUPT_LATCHED_FLAGS: rdata_nxt = visible;
        irq_unit_pkg::ADDR_COMMON_MODE_TOLERANCE:   rdata_nxt = cmtol_r;
        default:                                    rdata_nxt = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt output generation
  // ----------------------------------------------------------------
  logic [31:0] tmr_r, tmr_nxt;
  logic        busy_r, busy_nxt;
  logic        irq_nxt;
  logic        pin_r, pin_nxt;

  // current mode and what may drive the pin
  assign mode         = cfg_r[irq_unit_pkg::POS_EVENT_MODE_HI:
                              irq_unit_pkg::POS_EVENT_MODE_LO];
  assign flag_pending = |(flags_r & ~mask_r & 8'hF8);
  assign new_event    = |(events & ~mask_r & 8'hF8);

  // timer and asserted level per event mode
  always_comb begin
    tmr_nxt  = tmr_r;
    busy_nxt = busy_r;
    irq_nxt  = 1'b0;
    unique case (mode)
      irq_unit_pkg::MODE_PERIODIC: begin
        busy_nxt = 1'b0;
        if (flag_pending) begin
          // on for the first part of each period, first pulse full length
          irq_nxt = (tmr_r < 32'(PULSE_CYCLES));
          if (tmr_r >= 32'(PERIOD_CYCLES - 1)) begin
            tmr_nxt = 32'h0;
          end else begin
            tmr_nxt = tmr_r + 32'h1;
          end
        end else begin
          tmr_nxt = 32'h0;
        end
      end
      irq_unit_pkg::MODE_ONESHOT: begin
        // a new event restarts the pulse if one is running
        if (new_event) begin
          busy_nxt = 1'b1;
          tmr_nxt  = 32'h0;
        end else if (busy_r) begin
          if (tmr_r >= 32'(PULSE_CYCLES - 1)) begin
            busy_nxt = 1'b0;
            tmr_nxt  = 32'h0; // clean count for a later mode change
          end else begin
            tmr_nxt = tmr_r + 32'h1;
          end
        end
        irq_nxt = busy_nxt;
      end
      default: begin
        busy_nxt = 1'b0;
        tmr_nxt  = 32'h0;
        irq_nxt  = flag_pending;
      end
    endcase
  end

  // register timer state
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tmr_r  <= 32'h0;
      busy_r <= 1'b0;
    end else begin
      tmr_r  <= tmr_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------
  // pin level from the asserted state and the polarity bit
  always_comb begin
    pin_nxt = cfg_r[irq_unit_pkg::POS_IRQ_POLARITY] ? irq_nxt
                                                    : ~irq_nxt;
  end

  // pin register; resets high, the idle level of an active-low pin
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_r <= 1'b1;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output comes straight from a register
  assign o_reg_rdata           = rdata_r;
  assign o_chan_a_cm_tolerance = cmtol_r[irq_unit_pkg::POS_CHAN_A_CM_HI:
                                         irq_unit_pkg::POS_CHAN_A_CM_LO];
  assign o_chan_b_cm_tolerance = cmtol_r[irq_unit_pkg::POS_CHAN_B_CM_HI:
                                         irq_unit_pkg::POS_CHAN_B_CM_LO];
  assign o_irq_active_low_pin  = pin_r;

endmodule
`default_nettype wire

// file: rtl/irq_unit_pkg.sv
`default_nettype none
package irq_unit_pkg;
  // register offsets on the control port
  localparam logic [7:0] ADDR_INTERRUPT_CONFIG        = 8'h32;
  localparam logic [7:0] ADDR_INTERRUPT_MASKS         = 8'h33;
  localparam logic [7:0] ADDR_INTERRUPT_LATCHED_FLAGS = 8'h36;
  localparam logic [7:0] ADDR_COMMON_MODE_TOLERANCE   = 8'h3A;
  // reset values
  localparam logic [7:0] RST_INTERRUPT_CONFIG        = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_MASKS         = 8'hFF;
  localparam logic [7:0] RST_INTERRUPT_LATCHED_FLAGS = 8'h00;
  localparam logic [7:0] RST_COMMON_MODE_TOLERANCE   = 8'h00;
  // interrupt_config fields
  localparam int POS_IRQ_POLARITY         = 7;
  localparam int POS_EVENT_MODE_HI        = 6;
  localparam int POS_EVENT_MODE_LO        = 5;
  localparam int POS_FLAG_READBACK_SELECT = 2;
  // writable bits of the config and common-mode tolerance registers
  localparam logic [7:0] WMASK_INTERRUPT_CONFIG      = 8'hE4;
  localparam logic [7:0] WMASK_COMMON_MODE_TOLERANCE = 8'hF0;
  // event source bit positions (flags and masks share them)
  localparam int POS_SERIAL_CLK_ERR = 7;
  localparam int POS_PLL_LOCK       = 6;
  localparam int POS_MIX_SATURATE   = 5;
  localparam int POS_VOICE_UP       = 4;
  localparam int POS_VOICE_DOWN     = 3;
  localparam int NUM_SOURCES        = 5;
  // common-mode tolerance fields
  localparam int POS_CHAN_A_CM_HI = 7;
  localparam int POS_CHAN_A_CM_LO = 6;
  localparam int POS_CHAN_B_CM_HI = 5;
  localparam int POS_CHAN_B_CM_LO = 4;
  // event modes
  localparam logic [1:0] MODE_LEVEL    = 2'h0;
  localparam logic [1:0] MODE_RSVD     = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_ONESHOT  = 2'h3;
  // timing
  localparam int CLK_HZ      = 10_000_000;
  localparam int PULSE_US    = 2000;
  localparam int PERIOD_US   = 4000;
  localparam int PULSE_CYC   = PULSE_US * (CLK_HZ / 1_000_000);
  localparam int PERIOD_CYC  = PERIOD_US * (CLK_HZ / 1_000_000);
endpackage
`default_nettype wire

// file: tb/irq_host_model.sv
`default_nettype none
module irq_host_model (
  input  wire logic i_clk,
  input  wire logic i_pin,
  input  wire logic i_active_high,
  input  wire logic i_clear,
  output logic      o_irq,
  output var int    o_on_cycles
);
  timeunit 1ns;
  timeprecision 1ns;
  // host view of the pin: request when it sits at the active level
  assign o_irq = (i_pin == i_active_high);
  // asserted cycles seen since the last clear
  always_ff @(posedge i_clk) begin
    if (i_clear) o_on_cycles <= 0;
    else if (o_irq) o_on_cycles <= o_on_cycles + 1;
  end
endmodule
`default_nettype wire

// file: tb/irq_unit_checker.sv
`default_nettype none
module irq_unit_checker (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [1:0] o_chan_a_cm_tolerance,
  input wire logic [1:0] o_chan_b_cm_tolerance,
  input wire logic       o_irq_active_low_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // port checks on the register side and the pin
  // ----
  default clocking cb @(posedge i_clk); endclocking
  a_reset_idle: assert property (i_reset |=> o_irq_active_low_pin
    && o_reg_rdata == 8'h00) else $error("pin not idle after reset");
  a_cm_reset: assert property (i_reset |=> o_chan_a_cm_tolerance == 2'h0
    && o_chan_b_cm_tolerance == 2'h0) else $error("cm not reset");
  a_mask_reset: assert property (i_reset ##1 (!i_reset && i_reg_rd
    && i_reg_addr == 8'h33) |=> o_reg_rdata == 8'hFF)
    else $error("masks not all ones after reset");
  a_cm_write: assert property (disable iff (i_reset)
    i_reg_wr && i_reg_addr == 8'h3A |=> {o_chan_a_cm_tolerance,
    o_chan_b_cm_tolerance} == $past(i_reg_wdata[7:4]))
    else $error("cm fields not loaded");
  a_cm_hold: assert property (disable iff (i_reset)
    !(i_reg_wr && i_reg_addr == 8'h3A) |=> $stable({o_chan_a_cm_tolerance,
    o_chan_b_cm_tolerance})) else $error("cm fields changed unwritten");
  a_cm_readback: assert property (disable iff (i_reset)
    i_reg_rd && i_reg_addr == 8'h3A |=> o_reg_rdata == {$past(
    {o_chan_a_cm_tolerance, o_chan_b_cm_tolerance}), 4'h0})
    else $error("cm readback wrong");
  a_flag_low_zero: assert property (disable iff (i_reset)
    i_reg_rd && i_reg_addr == 8'h36 |=> o_reg_rdata[2:0] == 3'h0)
    else $error("flag low bits not zero");
  a_cfg_rsvd_zero: assert property (disable iff (i_reset)
    i_reg_rd && i_reg_addr == 8'h32 |=> (o_reg_rdata & 8'h1B) == 8'h00)
    else $error("config reserved bits not zero");
endmodule
bind audio_adc_interrupt_unit irq_unit_checker u_chk (.i_clk, .i_reset,
  .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
  .o_chan_a_cm_tolerance, .o_chan_b_cm_tolerance, .o_irq_active_low_pin);
`default_nettype wire

// file: tb/tb_audio_adc_interrupt_unit.sv
`default_nettype none
module tb_audio_adc_interrupt_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 0, i_reset = 1, wr = 0, rd = 0, clr = 0, pol = 0;
  logic [7:0]  addr = 0, wdata = 0, rdata;
  logic [4:0]  ev = 0;
  logic [1:0]  cm_a, cm_b;
  logic        pin, irq;
  int          on_cyc, fails = 0, num_checks = 0, cyc = 0, i;
  logic [23:0] rows [5] = '{24'h32FFE4, 24'h330707, 24'h3A5F50,
                            24'h36FF00, 24'h10AA00};
  audio_adc_interrupt_unit #(.PULSE_CYCLES(4), .PERIOD_CYCLES(8)) u_dut (
    .i_clk, .i_reset, .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_serial_clk_err(ev[4]),
    .i_pll_lock(ev[3]), .i_mix_saturate(ev[2]), .i_voice_up(ev[1]),
    .i_voice_down(ev[0]), .o_chan_a_cm_tolerance(cm_a),
    .o_chan_b_cm_tolerance(cm_b), .o_irq_active_low_pin(pin));
  irq_host_model u_host (.i_clk, .i_pin(pin), .i_active_high(pol),
    .i_clear(clr), .o_irq(irq), .o_on_cycles(on_cyc));
  // clock and hang guard
  initial forever #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      test_done;
    end
  end
  task chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %0h got %0h", n, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wreg(input logic [7:0] a, d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    if (a == 8'h32) pol = d[7];
    @(posedge i_clk) wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task rreg(input logic [7:0] a, e);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk) rd <= 1'b0;
    @(negedge i_clk) chk("rdata", e, rdata);
    @(posedge i_clk);
  endtask
  task fire(input logic [4:0] v);
    ev <= v;
    @(posedge i_clk) ev <= 5'h00;
    @(posedge i_clk);
  endtask
  task irq_chk(input int n, input logic e);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk) chk("irq", e, irq);
    @(posedge i_clk);
  endtask
  // count asserted cycles over a window, optionally firing events first
  task win(input int n, input int e, input logic [4:0] v);
    ev <= v;
    clr <= 1'b1;
    @(posedge i_clk) clr <= 1'b0;
    ev <= 5'h00;
    repeat (n) @(posedge i_clk);
    @(negedge i_clk) chk("on_cycles", e, on_cyc);
    @(posedge i_clk);
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    for (i = 0; i < 5; i++) begin
      wreg(rows[i][23:16], rows[i][15:8]);
      rreg(rows[i][23:16], rows[i][7:0]);
    end
    chk("cm", 4'h5, {cm_a, cm_b});
    wreg(8'h32, 8'h00);
    for (i = 0; i < 5; i++) begin
      fire(5'h01 << i);
      irq_chk(0, 1'b1);
      rreg(8'h36, 8'h08 << i);
      irq_chk(1, 1'b0);
    end
    wreg(8'h33, 8'hBF);
    fire(5'h10);
    irq_chk(1, 1'b0);
    rreg(8'h36, 8'h80);
    wreg(8'h32, 8'h04);
    fire(5'h18);
    rreg(8'h36, 8'h40);
    rreg(8'h36, 8'h00);
    wreg(8'h32, 8'h00);
    rreg(8'h36, 8'h80);
    wreg(8'h33, 8'h07);
    wreg(8'h32, 8'hE0);
    win(10, 4, 5'h08);
    wreg(8'h32, 8'hC0);
    repeat (4) @(posedge i_clk);
    win(16, 8, 5'h00);
    rreg(8'h36, 8'h40);
    irq_chk(5, 1'b0);
    i_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    rreg(8'h33, 8'hFF);
    chk("pin", 1'b1, pin);
    rreg(8'h32, 8'h00);
    rreg(8'h36, 8'h00);
    test_done;
  end
endmodule
`default_nettype wire
